// *** rtl/sgw_param_map.sv ***
// Behaviour
// - connected-heads bit field, bit i-1 head i
// - registered-heads bit field, same bit layout
// - laser word: 0 off, 1 on
// - relay word: off, on, open, closed
// - two analog inputs as read-only floats
// - output mode codes 5..10 or 99
// - output source: head number or fixed
// - source quantity: 1 internal, 2 object
// - fixed value kept within mode span
// - scale limits within head measurement range
// - head status error flags bits 1..5
// - head status unit bit0, compensation bit7
// - head addresses prefixed, enrolled heads only
// - channel addresses embed index, fitted only
// - 32-bit values: high word first
// - floats in IEEE-754 single format
`timescale 1ns/1ps
module sgw_param_map #(
  parameter int NUM_HEADS = 8,
  parameter int NUM_AO    = 2,
  parameter bit HAS_LASER = 1'b1
) (
  // clock, reset, enable
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_B,
  input  wire logic                    CE,
  // word request port
  input  wire logic                    REQ_VALID,
  input  wire logic                    REQ_WRITE,
  input  wire logic [1:0]              REQ_SPACE,
  input  wire logic [15:0]             REQ_ADDR,
  input  wire logic [15:0]             REQ_WDATA,
  // word answer port
  output logic                         RSP_VALID,
  output logic [15:0]                  RSP_DATA,
  output logic [7:0]                   RSP_ERROR,
  // gateway state
  input  wire logic [NUM_HEADS-1:0]    HEAD_CONNECTED,
  input  wire logic [NUM_HEADS-1:0]    HEAD_REGISTERED,
  input  wire logic [31:0]             AIN1_LEVEL,
  input  wire logic [31:0]             AIN2_LEVEL,
  input  wire logic                    TRIGGER_ON,
  // per-head state, head 1 in the low slice
  input  wire logic [8*NUM_HEADS-1:0]  HEAD_STATUS,
  input  wire logic [64*NUM_HEADS-1:0] HEAD_SERIAL,
  input  wire logic [64*NUM_HEADS-1:0] HEAD_IDENT,
  input  wire logic [64*NUM_HEADS-1:0] HEAD_FWREV,
  input  wire logic [16*NUM_HEADS-1:0] HEAD_BUSADDR,
  input  wire logic [32*NUM_HEADS-1:0] HEAD_SPECIAL,
  input  wire logic [32*NUM_HEADS-1:0] HEAD_RANGE_LOW,
  input  wire logic [32*NUM_HEADS-1:0] HEAD_RANGE_HIGH,
  input  wire logic [32*NUM_HEADS-1:0] HEAD_TARGET,
  input  wire logic [32*NUM_HEADS-1:0] HEAD_INTERNAL,
  // control outputs
  output logic                         LASER_ON,
  output logic [1:0]                   RELAY_CTRL,
  output logic [16*NUM_AO-1:0]         AO_MODE,
  output logic [16*NUM_AO-1:0]         AO_SOURCE,
  output logic [16*NUM_AO-1:0]         AO_QUANTITY,
  output logic [32*NUM_AO-1:0]         AO_FIXED,
  output logic [32*NUM_AO-1:0]         AO_SCALE_LOW,
  output logic [32*NUM_AO-1:0]         AO_SCALE_HIGH,
  output logic [32*NUM_HEADS-1:0]      HEAD_AMBIENT_COMP
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // no nan handling: software is trusted not to write nan limits
  function automatic logic f_le(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31])
      return a[31] | ((a[30:0] == 31'h0) && (b[30:0] == 31'h0));
    else if (!a[31])
      return a[30:0] <= b[30:0];
    else
      return a[30:0] >= b[30:0];
  endfunction

  function automatic logic [15:0] w32(input logic [31:0] v, input int w);
    return (w == 0) ? v[31:16] : v[15:0];
  endfunction

  function automatic logic [15:0] w64(input logic [63:0] v, input int w);
    return v[(3-w)*16 +: 16];
  endfunction

  function automatic logic in_win(input int ofs, input int base, input int words);
    return (ofs >= base) && (ofs < base + words);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [7:0]  rsp_error;
  logic [15:0] laser_ctrl;
  logic [15:0] relay_ctrl;
  logic [15:0] ao_mode   [NUM_AO];
  logic [15:0] ao_src    [NUM_AO];
  logic [15:0] ao_qty    [NUM_AO];
  logic [31:0] ao_fix    [NUM_AO];
  logic [31:0] ao_low    [NUM_AO];
  logic [31:0] ao_high   [NUM_AO];
  logic [31:0] hd_amb    [NUM_HEADS];
  logic [15:0] stage_hi;
  logic [15:0] stage_addr;
  logic        stage_ok;

  logic        next_rsp_valid;
  logic [15:0] next_rsp_data;
  logic [7:0]  next_rsp_error;
  logic [15:0] next_laser_ctrl;
  logic [15:0] next_relay_ctrl;
  logic [15:0] next_ao_mode [NUM_AO];
  logic [15:0] next_ao_src  [NUM_AO];
  logic [15:0] next_ao_qty  [NUM_AO];
  logic [31:0] next_ao_fix  [NUM_AO];
  logic [31:0] next_ao_low  [NUM_AO];
  logic [31:0] next_ao_high [NUM_AO];
  logic [31:0] next_hd_amb  [NUM_HEADS];
  logic [15:0] next_stage_hi;
  logic [15:0] next_stage_addr;
  logic        next_stage_ok;

  // decode scratch
  int          a;
  int          hsel;
  int          hofs;
  int          kch;
  int          kofs;
  int          s;
  logic        hit_head;
  logic        hit_ao;
  logic        rd_ok;
  logic        wr_ok;
  logic        pair_ok;
  logic [7:0]  err;
  logic [15:0] rd;
  logic [31:0] cand;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [7:0]  conn8;
  logic [7:0]  regd8;

  assign conn8 = 8'(HEAD_CONNECTED);
  assign regd8 = 8'(HEAD_REGISTERED);

  ////////////////////////////////////////////////////////////////////////////////
  // request decode and register update

  always_comb
  begin
    next_rsp_valid  = 1'b0;
    next_rsp_data   = rsp_data;
    next_rsp_error  = rsp_error;
    next_laser_ctrl = laser_ctrl;
    next_relay_ctrl = relay_ctrl;
    next_ao_mode    = ao_mode;
    next_ao_src     = ao_src;
    next_ao_qty     = ao_qty;
    next_ao_fix     = ao_fix;
    next_ao_low     = ao_low;
    next_ao_high    = ao_high;
    next_hd_amb     = hd_amb;
    next_stage_hi   = stage_hi;
    next_stage_addr = stage_addr;
    next_stage_ok   = stage_ok;
    a        = int'(REQ_ADDR);
    hsel     = 0;
    hofs     = 0;
    kch      = 0;
    kofs     = 0;
    s        = 0;
    hit_head = 1'b0;
    hit_ao   = 1'b0;
    err      = sgw_pkg::ERR_NONE;
    rd       = 16'h0000;
    lo       = sgw_pkg::FP_ZERO;
    hi       = sgw_pkg::FP_ZERO;
    rd_ok    = REQ_VALID && !REQ_WRITE;
    wr_ok    = REQ_VALID && REQ_WRITE && (REQ_SPACE == sgw_pkg::SP_HOLDING);
    // two-word writes land on the high word first, then commit on the low word
    pair_ok  = stage_ok && (stage_addr == REQ_ADDR - 16'h0001);
    cand     = {stage_hi, REQ_WDATA};

    for (int i = 0; i < NUM_HEADS; i++)
    begin
      if (a >= (i + 1) * sgw_pkg::HD_STRIDE && a < (i + 2) * sgw_pkg::HD_STRIDE)
      begin
        hit_head = 1'b1;
        hsel     = i;
        hofs     = a - (i + 1) * sgw_pkg::HD_STRIDE;
      end
    end
    if (a >= sgw_pkg::AO_BASE && a < sgw_pkg::AO_BASE + 10 * sgw_pkg::AO_STRIDE)
    begin
      hit_ao = 1'b1;
      for (int j = 0; j < 10; j++)
      begin
        if (a >= sgw_pkg::AO_BASE + j * sgw_pkg::AO_STRIDE)
        begin
          kch  = j;
          kofs = a - sgw_pkg::AO_BASE - j * sgw_pkg::AO_STRIDE;
        end
      end
    end

    if (REQ_VALID)
    begin
      next_rsp_valid = 1'b1;
      if (REQ_WRITE && REQ_SPACE != sgw_pkg::SP_HOLDING)
        err = sgw_pkg::ERR_OTHER;
      else if (hit_head)
      begin
        if (!HEAD_REGISTERED[hsel])
          err = sgw_pkg::ERR_HEAD;
        else if (rd_ok && REQ_SPACE == sgw_pkg::SP_DISCRETE
                 && in_win(hofs, sgw_pkg::HD_STATUS, 8))
          rd = {15'h0000, HEAD_STATUS[hsel*8 + hofs - sgw_pkg::HD_STATUS]};
        else if (rd_ok && REQ_SPACE == sgw_pkg::SP_INPUT)
        begin
          if (in_win(hofs, sgw_pkg::HD_SERIAL, 4))
            rd = w64(HEAD_SERIAL[hsel*64 +: 64], hofs - sgw_pkg::HD_SERIAL);
          else if (in_win(hofs, sgw_pkg::HD_IDENT, 4))
            rd = w64(HEAD_IDENT[hsel*64 +: 64], hofs - sgw_pkg::HD_IDENT);
          else if (in_win(hofs, sgw_pkg::HD_FWREV, 4))
            rd = w64(HEAD_FWREV[hsel*64 +: 64], hofs - sgw_pkg::HD_FWREV);
          else if (hofs == sgw_pkg::HD_BUSADDR)
            rd = HEAD_BUSADDR[hsel*16 +: 16];
          else if (in_win(hofs, sgw_pkg::HD_SPECIAL, 2))
            rd = w32(HEAD_SPECIAL[hsel*32 +: 32], hofs - sgw_pkg::HD_SPECIAL);
          else if (in_win(hofs, sgw_pkg::HD_RLOW, 2))
            rd = w32(HEAD_RANGE_LOW[hsel*32 +: 32], hofs - sgw_pkg::HD_RLOW);
          else if (in_win(hofs, sgw_pkg::HD_RHIGH, 2))
            rd = w32(HEAD_RANGE_HIGH[hsel*32 +: 32], hofs - sgw_pkg::HD_RHIGH);
          else if (in_win(hofs, sgw_pkg::HD_TARGET, 2))
            rd = w32(HEAD_TARGET[hsel*32 +: 32], hofs - sgw_pkg::HD_TARGET);
          else if (in_win(hofs, sgw_pkg::HD_INTERNAL, 2))
            rd = w32(HEAD_INTERNAL[hsel*32 +: 32], hofs - sgw_pkg::HD_INTERNAL);
          else
            err = sgw_pkg::ERR_OTHER;
        end
        else if (REQ_SPACE == sgw_pkg::SP_HOLDING && in_win(hofs, sgw_pkg::HD_AMBIENT, 2))
        begin
          if (rd_ok)
            rd = w32(hd_amb[hsel], hofs - sgw_pkg::HD_AMBIENT);
          else if (hofs == sgw_pkg::HD_AMBIENT)
          begin
            next_stage_hi   = REQ_WDATA;
            next_stage_addr = REQ_ADDR;
            next_stage_ok   = 1'b1;
          end
          else if (pair_ok)
            next_hd_amb[hsel] = cand;
          else
            err = sgw_pkg::ERR_RANGE;
        end
        else
          err = sgw_pkg::ERR_OTHER;
      end
      else if (hit_ao)
      begin
        if (kch < 1 || kch > NUM_AO)
          err = sgw_pkg::ERR_AO;
        else if (REQ_SPACE != sgw_pkg::SP_HOLDING || kofs == 9)
          err = sgw_pkg::ERR_OTHER;
        else
        begin
          s = int'(ao_src[kch-1]);
          if (s >= 1 && s <= NUM_HEADS)
          begin
            lo = HEAD_RANGE_LOW[(s-1)*32 +: 32];
            hi = HEAD_RANGE_HIGH[(s-1)*32 +: 32];
          end
          if (rd_ok)
          begin
            if (kofs == sgw_pkg::AO_MODE)
              rd = ao_mode[kch-1];
            else if (kofs == sgw_pkg::AO_SRC)
              rd = ao_src[kch-1];
            else if (kofs == sgw_pkg::AO_QTY)
              rd = ao_qty[kch-1];
            else if (in_win(kofs, sgw_pkg::AO_FIX, 2))
              rd = w32(ao_fix[kch-1], kofs - sgw_pkg::AO_FIX);
            else if (in_win(kofs, sgw_pkg::AO_LOW, 2))
              rd = w32(ao_low[kch-1], kofs - sgw_pkg::AO_LOW);
            else
              rd = w32(ao_high[kch-1], kofs - sgw_pkg::AO_HIGH);
          end
          else if (kofs == sgw_pkg::AO_MODE)
          begin
            if ((REQ_WDATA >= sgw_pkg::MODE_TCJ && REQ_WDATA <= sgw_pkg::MODE_V10)
                || REQ_WDATA == sgw_pkg::MODE_OFF)
              next_ao_mode[kch-1] = REQ_WDATA;
            else
              err = sgw_pkg::ERR_MODE;
          end
          else if (kofs == sgw_pkg::AO_SRC)
          begin
            if (REQ_WDATA == 16'h0000
                || (int'(REQ_WDATA) <= NUM_HEADS && regd8[REQ_WDATA[2:0] - 3'h1]))
              next_ao_src[kch-1] = REQ_WDATA;
            else
              err = sgw_pkg::ERR_HEAD;
          end
          else if (kofs == sgw_pkg::AO_QTY)
          begin
            if (REQ_WDATA == sgw_pkg::QTY_INT || REQ_WDATA == sgw_pkg::QTY_OBJ)
              next_ao_qty[kch-1] = REQ_WDATA;
            else
              err = sgw_pkg::ERR_RANGE;
          end
          else if (kofs == sgw_pkg::AO_FIX || kofs == sgw_pkg::AO_LOW
                   || kofs == sgw_pkg::AO_HIGH)
          begin
            next_stage_hi   = REQ_WDATA;
            next_stage_addr = REQ_ADDR;
            next_stage_ok   = 1'b1;
          end
          else if (!pair_ok)
            err = sgw_pkg::ERR_RANGE;
          else if (kofs == sgw_pkg::AO_FIX + 1)
          begin
            // thermocouple spans follow the head range, voltage spans are fixed
            if ((ao_mode[kch-1] == sgw_pkg::MODE_V5
                 && !(f_le(sgw_pkg::FP_ZERO, cand) && f_le(cand, sgw_pkg::FP_FIVE)))
                || (ao_mode[kch-1] == sgw_pkg::MODE_V10
                 && !(f_le(sgw_pkg::FP_ZERO, cand) && f_le(cand, sgw_pkg::FP_TEN)))
                || (ao_mode[kch-1] < sgw_pkg::MODE_V5 && s >= 1
                 && !(f_le(lo, cand) && f_le(cand, hi))))
              err = sgw_pkg::ERR_RANGE;
            else
              next_ao_fix[kch-1] = cand;
          end
          else if (s >= 1 && !(f_le(lo, cand) && f_le(cand, hi)))
            err = sgw_pkg::ERR_RANGE;
          else if (kofs == sgw_pkg::AO_LOW + 1)
            next_ao_low[kch-1] = cand;
          else
            next_ao_high[kch-1] = cand;
        end
      end
      else if (rd_ok && REQ_SPACE == sgw_pkg::SP_DISCRETE && in_win(a, sgw_pkg::ADDR_CONN, 8))
        rd = {15'h0000, conn8[a - sgw_pkg::ADDR_CONN]};
      else if (rd_ok && REQ_SPACE == sgw_pkg::SP_DISCRETE && in_win(a, sgw_pkg::ADDR_REGD, 8))
        rd = {15'h0000, regd8[a - sgw_pkg::ADDR_REGD]};
      else if (rd_ok && REQ_SPACE == sgw_pkg::SP_INPUT && in_win(a, sgw_pkg::ADDR_AIN1, 2))
        rd = w32(AIN1_LEVEL, a - sgw_pkg::ADDR_AIN1);
      else if (rd_ok && REQ_SPACE == sgw_pkg::SP_INPUT && in_win(a, sgw_pkg::ADDR_AIN2, 2))
        rd = w32(AIN2_LEVEL, a - sgw_pkg::ADDR_AIN2);
      else if (rd_ok && REQ_SPACE == sgw_pkg::SP_INPUT && a == sgw_pkg::ADDR_TRIG)
        rd = {15'h0000, TRIGGER_ON};
      else if (REQ_SPACE == sgw_pkg::SP_HOLDING && a == sgw_pkg::ADDR_LASER && HAS_LASER)
      begin
        if (rd_ok)
          rd = laser_ctrl;
        else if (REQ_WDATA == sgw_pkg::LASER_OFF || REQ_WDATA == sgw_pkg::LASER_ON)
          next_laser_ctrl = REQ_WDATA;
        else
          err = sgw_pkg::ERR_RANGE;
      end
      else if (REQ_SPACE == sgw_pkg::SP_HOLDING && a == sgw_pkg::ADDR_RELAY)
      begin
        if (rd_ok)
          rd = relay_ctrl;
        else if (REQ_WDATA <= sgw_pkg::RELAY_MAX)
          next_relay_ctrl = REQ_WDATA;
        else
          err = sgw_pkg::ERR_RANGE;
      end
      else
        err = sgw_pkg::ERR_OTHER;

      // any holding-space write to the pending pair's low word, good or bad, closes the pair
      if (wr_ok && stage_ok && REQ_ADDR == stage_addr + 16'h0001)
        next_stage_ok = 1'b0;
      next_rsp_data  = (err == sgw_pkg::ERR_NONE) ? rd : 16'h0000;
      next_rsp_error = err;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rsp_valid  <= 1'b0;
      rsp_data   <= 16'h0000;
      rsp_error  <= sgw_pkg::ERR_NONE;
      laser_ctrl <= sgw_pkg::LASER_OFF;
      relay_ctrl <= 16'h0000;
      for (int k = 0; k < NUM_AO; k++)
      begin
        ao_mode[k] <= sgw_pkg::RST_MODE;
        ao_src[k]  <= sgw_pkg::RST_SRC;
        ao_qty[k]  <= sgw_pkg::RST_QTY;
        ao_fix[k]  <= sgw_pkg::FP_ZERO;
        ao_low[k]  <= sgw_pkg::FP_ZERO;
        ao_high[k] <= sgw_pkg::FP_ZERO;
      end
      for (int h = 0; h < NUM_HEADS; h++)
        hd_amb[h] <= sgw_pkg::FP_ZERO;
      stage_hi   <= 16'h0000;
      stage_addr <= 16'h0000;
      stage_ok   <= 1'b0;
    end
    else if (CE)
    begin
      rsp_valid  <= next_rsp_valid;
      rsp_data   <= next_rsp_data;
      rsp_error  <= next_rsp_error;
      laser_ctrl <= next_laser_ctrl;
      relay_ctrl <= next_relay_ctrl;
      ao_mode    <= next_ao_mode;
      ao_src     <= next_ao_src;
      ao_qty     <= next_ao_qty;
      ao_fix     <= next_ao_fix;
      ao_low     <= next_ao_low;
      ao_high    <= next_ao_high;
      hd_amb     <= next_hd_amb;
      stage_hi   <= next_stage_hi;
      stage_addr <= next_stage_addr;
      stage_ok   <= next_stage_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign RSP_VALID  = rsp_valid;
  assign RSP_DATA   = rsp_data;
  assign RSP_ERROR  = rsp_error;
  assign LASER_ON   = laser_ctrl[0];
  assign RELAY_CTRL = relay_ctrl[1:0];

  for (genvar g = 0; g < NUM_AO; g++)
  begin : g_ao
    assign AO_MODE[g*16 +: 16]       = ao_mode[g];
    assign AO_SOURCE[g*16 +: 16]     = ao_src[g];
    assign AO_QUANTITY[g*16 +: 16]   = ao_qty[g];
    assign AO_FIXED[g*32 +: 32]      = ao_fix[g];
    assign AO_SCALE_LOW[g*32 +: 32]  = ao_low[g];
    assign AO_SCALE_HIGH[g*32 +: 32] = ao_high[g];
  end

  for (genvar g = 0; g < NUM_HEADS; g++)
  begin : g_hd
    assign HEAD_AMBIENT_COMP[g*32 +: 32] = hd_amb[g];
  end

endmodule

// *** rtl/sgw_pkg.sv ***
package sgw_pkg;

  // access spaces of the word port
  localparam logic [1:0] SP_DISCRETE = 2'h0;
  localparam logic [1:0] SP_INPUT    = 2'h1;
  localparam logic [1:0] SP_HOLDING  = 2'h2;

  // gateway-level item addresses
  localparam int ADDR_CONN   = 32'h0000_0064;
  localparam int ADDR_REGD   = 32'h0000_006e;
  localparam int ADDR_LASER  = 32'h0000_0078;
  localparam int ADDR_RELAY  = 32'h0000_0082;
  localparam int ADDR_AIN1   = 32'h0000_019a;
  localparam int ADDR_AIN2   = 32'h0000_01a4;
  localparam int ADDR_TRIG   = 32'h0000_01ae;

  // analog output block: base + channel * stride + offset
  localparam int AO_BASE     = 32'h0000_01f4;
  localparam int AO_STRIDE   = 32'h0000_000a;
  localparam int AO_MODE     = 32'h0000_0000;
  localparam int AO_SRC      = 32'h0000_0001;
  localparam int AO_QTY      = 32'h0000_0002;
  localparam int AO_FIX      = 32'h0000_0003;
  localparam int AO_LOW      = 32'h0000_0005;
  localparam int AO_HIGH     = 32'h0000_0007;

  // per-head block: head number * stride + offset
  localparam int HD_STRIDE   = 32'h0000_03e8;
  localparam int HD_STATUS   = 32'h0000_0005;
  localparam int HD_SERIAL   = 32'h0000_000a;
  localparam int HD_IDENT    = 32'h0000_0014;
  localparam int HD_FWREV    = 32'h0000_001e;
  localparam int HD_BUSADDR  = 32'h0000_0028;
  localparam int HD_SPECIAL  = 32'h0000_0032;
  localparam int HD_RLOW     = 32'h0000_003c;
  localparam int HD_RHIGH    = 32'h0000_0046;
  localparam int HD_TARGET   = 32'h0000_0050;
  localparam int HD_INTERNAL = 32'h0000_005a;
  localparam int HD_AMBIENT  = 32'h0000_0064;

  // control codes
  localparam logic [15:0] LASER_OFF   = 16'h0000;
  localparam logic [15:0] LASER_ON    = 16'h0001;
  localparam logic [15:0] RELAY_MAX   = 16'h0003;
  localparam logic [15:0] MODE_TCJ    = 16'h0005;
  localparam logic [15:0] MODE_V5     = 16'h0009;
  localparam logic [15:0] MODE_V10    = 16'h000a;
  localparam logic [15:0] MODE_OFF    = 16'h0063;
  localparam logic [15:0] QTY_INT     = 16'h0001;
  localparam logic [15:0] QTY_OBJ     = 16'h0002;

  // answer codes
  localparam logic [7:0] ERR_NONE  = 8'h00;
  localparam logic [7:0] ERR_RANGE = 8'h01;
  localparam logic [7:0] ERR_HEAD  = 8'h02;
  localparam logic [7:0] ERR_AO    = 8'h03;
  localparam logic [7:0] ERR_MODE  = 8'h04;
  localparam logic [7:0] ERR_OTHER = 8'h63;

  // single-precision span limits
  localparam logic [31:0] FP_ZERO = 32'h0000_0000;
  localparam logic [31:0] FP_FIVE = 32'h40a0_0000;
  localparam logic [31:0] FP_TEN  = 32'h4120_0000;

  // values after reset
  localparam logic [15:0] RST_MODE = 16'h0063;
  localparam logic [15:0] RST_SRC  = 16'h0000;
  localparam logic [15:0] RST_QTY  = 16'h0002;

endpackage

// *** verification/sgw_param_map_props.sv ***
`timescale 1ns/1ps
module sgw_param_map_props #(
  parameter int NUM_HEADS = 8,
  parameter int NUM_AO    = 2
) (
  // clock, reset and request
  input wire logic                 CLK_SYS,
  input wire logic                 RST_B,
  input wire logic                 CE,
  input wire logic                 REQ_VALID,
  input wire logic                 REQ_WRITE,
  input wire logic [1:0]           REQ_SPACE,
  input wire logic [15:0]          REQ_ADDR,
  input wire logic [15:0]          REQ_WDATA,
  // answer and state
  input wire logic                 RSP_VALID,
  input wire logic [15:0]          RSP_DATA,
  input wire logic [7:0]           RSP_ERROR,
  input wire logic [NUM_HEADS-1:0] HEAD_CONNECTED,
  input wire logic [NUM_HEADS-1:0] HEAD_REGISTERED,
  input wire logic [31:0]          AIN1_LEVEL,
  input wire logic                 LASER_ON,
  input wire logic [1:0]           RELAY_CTRL,
  input wire logic [16*NUM_AO-1:0] AO_MODE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  logic take;
  logic rd_in;
  logic hwr;
  assign take  = REQ_VALID && CE;
  assign rd_in = take && !REQ_WRITE && REQ_SPACE == 2'h1;
  assign hwr   = take && REQ_WRITE && REQ_SPACE == 2'h2;

  chk_conn_bit: assert property (take && !REQ_WRITE && REQ_SPACE == 2'h0
    && REQ_ADDR inside {[100:107]} |=> RSP_VALID
    && RSP_DATA == {15'h0000, $past(HEAD_CONNECTED[REQ_ADDR - 16'd100])})
    else $error("connected bit read wrong");
  chk_regd_bit: assert property (take && !REQ_WRITE && REQ_SPACE == 2'h0
    && REQ_ADDR inside {[110:117]} |-> ##1 RSP_VALID
    && RSP_DATA == {15'h0000, $past(HEAD_REGISTERED[REQ_ADDR - 16'd110])})
    else $error("registered bit read wrong");
  chk_laser_set: assert property (hwr && REQ_ADDR == 16'd120 && REQ_WDATA <= 16'h0001
    |=> LASER_ON == $past(REQ_WDATA[0]) && RSP_ERROR == 8'h00)
    else $error("laser word not applied");
  chk_relay_set: assert property (hwr && REQ_ADDR == 16'd130 && REQ_WDATA <= 16'h0003
    |=> RELAY_CTRL == $past(REQ_WDATA[1:0]) && RSP_VALID)
    else $error("relay word not applied");
  chk_relay_keep: assert property (hwr && REQ_ADDR == 16'd130 && REQ_WDATA > 16'h0003
    |=> $stable(RELAY_CTRL) && RSP_ERROR == 8'h01)
    else $error("bad relay code not refused");
  chk_ain_high: assert property (rd_in && REQ_ADDR == 16'd410
    |=> RSP_DATA == $past(AIN1_LEVEL[31:16]) && RSP_ERROR == 8'h00)
    else $error("input high word wrong");
  chk_ain_low: assert property (rd_in && REQ_ADDR == 16'd411
    |=> RSP_DATA == $past(AIN1_LEVEL[15:0]))
    else $error("input low word wrong");
  chk_mode_bad: assert property (hwr && REQ_ADDR == 16'd510
    && !(REQ_WDATA inside {[5:10], 99}) |=> $stable(AO_MODE) && RSP_ERROR == 8'h04)
    else $error("bad mode not refused");

  cov_laser: cover property (hwr && REQ_ADDR == 16'd120);
  cov_relay_bad: cover property (hwr && REQ_ADDR == 16'd130 && REQ_WDATA > 16'h0003);
  cov_mode_bad: cover property (hwr && REQ_ADDR == 16'd510 && REQ_WDATA == 16'h000b);
endmodule

bind sgw_param_map sgw_param_map_props #(.NUM_HEADS(NUM_HEADS), .NUM_AO(NUM_AO)) sgw_props_i (.*);

// *** verification/sgw_master_model.sv ***
`timescale 1ns/1ps
module sgw_master_model (
  // clock and answer
  input  wire logic        CLK_SYS,
  input  wire logic        RSP_VALID,
  input  wire logic [15:0] RSP_DATA,
  input  wire logic [7:0]  RSP_ERROR,
  // request
  output logic             REQ_VALID = 1'b0,
  output logic             REQ_WRITE = 1'b0,
  output logic [1:0]       REQ_SPACE = 2'h0,
  output logic [15:0]      REQ_ADDR  = 16'h0000,
  output logic [15:0]      REQ_WDATA = 16'h0000
);
  int hang = 0;

  // one word per pulse; address and data lines show inverted values once released
  task automatic xfer(input logic w, input logic [1:0] sp, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q, output logic [7:0] e);
    int n;
    @(negedge CLK_SYS);
    REQ_VALID = 1'b1;
    REQ_WRITE = w;
    REQ_SPACE = sp;
    REQ_ADDR  = a;
    REQ_WDATA = d;
    @(negedge CLK_SYS);
    REQ_VALID = 1'b0;
    REQ_ADDR  = ~a;
    REQ_WDATA = ~d;
    for (n = 0; n < 4 && RSP_VALID !== 1'b1; n++)
      @(negedge CLK_SYS);
    if (n == 4)
      hang++;
    q = RSP_DATA;
    e = RSP_ERROR;
  endtask

  // a float goes as high word then low word
  task automatic wr32(input logic [15:0] a, input logic [31:0] v, output logic [7:0] e);
    logic [15:0] q;
    logic [7:0]  e1;
    xfer(1'b1, 2'h2, a, v[31:16], q, e1);
    xfer(1'b1, 2'h2, a + 16'h0001, v[15:0], q, e);
    e = (e1 !== 8'h00) ? e1 : e;
  endtask
endmodule

// *** verification/sgw_param_map_test.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sgw_param_map_test;
  int           miscompares = 0;
  int           check_count = 0;
  logic         CLK_SYS = 1'b0;
  logic         RST_B = 1'b0;
  logic         CE = 1'b1;
  logic         REQ_VALID, REQ_WRITE, RSP_VALID, LASER_ON;
  logic         TRIGGER_ON = 1'b1;
  logic [1:0]   REQ_SPACE, RELAY_CTRL;
  logic [15:0]  REQ_ADDR, REQ_WDATA, RSP_DATA;
  logic [7:0]   RSP_ERROR;
  logic [7:0]   HEAD_CONNECTED = 8'ha5;
  logic [7:0]   HEAD_REGISTERED = 8'h81;
  logic [31:0]  AIN1_LEVEL = 32'h4020_0000;
  logic [31:0]  AIN2_LEVEL = 32'h3fc0_0001;
  logic [63:0]  HEAD_STATUS = 64'hb5;
  logic [511:0] HEAD_SERIAL = 512'h5e01 << 48;
  logic [511:0] HEAD_IDENT = 512'h5e02 << 48;
  logic [511:0] HEAD_FWREV = 512'h5e03 << 48;
  logic [127:0] HEAD_BUSADDR = 128'h5e04 | (128'h0013 << 112);
  logic [255:0] HEAD_SPECIAL = 256'h5e05 << 16;
  logic [255:0] HEAD_RANGE_LOW = 256'h0;
  logic [255:0] HEAD_RANGE_HIGH = 256'h42c8 << 16;
  logic [255:0] HEAD_TARGET = 256'h5e08 << 16;
  logic [255:0] HEAD_INTERNAL = 256'h5e09 << 16;
  logic [31:0]  AO_MODE, AO_SOURCE, AO_QUANTITY;
  logic [63:0]  AO_FIXED, AO_SCALE_LOW, AO_SCALE_HIGH;
  logic [255:0] HEAD_AMBIENT_COMP;
  logic [15:0]  hmsw [9] = '{16'h5e01, 16'h5e02, 16'h5e03, 16'h5e04, 16'h5e05,
                             16'h0000, 16'h42c8, 16'h5e08, 16'h5e09};
  logic [15:0]  modes [7] = '{16'd5, 16'd6, 16'd7, 16'd8, 16'd9, 16'd10, 16'd99};

  sgw_param_map    sgw_param_map_i (.*);
  sgw_master_model sgw_master_model_i (.*);

  initial
  begin
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    miscompares += sgw_master_model_i.hang;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic rd(input logic [1:0] sp, input logic [15:0] a, x, input logic [7:0] xe);
    logic [15:0] q;
    logic [7:0]  e;
    sgw_master_model_i.xfer(1'b0, sp, a, 16'h0000, q, e);
    if (sgw_master_model_i.hang != 0)
      final_report();
    `CHK({e, q}, {xe, x})
  endtask

  task automatic wr(input logic [15:0] a, d, input logic [7:0] xe);
    logic [15:0] q;
    logic [7:0]  e;
    sgw_master_model_i.xfer(1'b1, 2'h2, a, d, q, e);
    if (sgw_master_model_i.hang != 0)
      final_report();
    `CHK(e, xe)
  endtask

  task automatic wr32(input logic [15:0] a, input logic [31:0] v, input logic [7:0] xe);
    logic [7:0] e;
    sgw_master_model_i.wr32(a, v, e);
    if (sgw_master_model_i.hang != 0)
      final_report();
    `CHK(e, xe)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge CLK_SYS);
    RST_B = 1'b1;
    `CHK({AO_MODE, AO_QUANTITY}, 64'h0063_0063_0002_0002)
    for (int i = 0; i < 8; i++)
    begin
      rd(2'h0, 16'd100 + 16'(i), {15'h0, HEAD_CONNECTED[i]}, 8'h00);
      rd(2'h0, 16'd110 + 16'(i), {15'h0, HEAD_REGISTERED[i]}, 8'h00);
      rd(2'h0, 16'd1005 + 16'(i), {15'h0, HEAD_STATUS[i]}, 8'h00);
    end
    rd(2'h1, 16'd410, 16'h4020, 8'h00);
    rd(2'h1, 16'd411, 16'h0000, 8'h00);
    rd(2'h1, 16'd421, 16'h0001, 8'h00);
    rd(2'h1, 16'd430, 16'h0001, 8'h00);
    for (int i = 0; i < 9; i++)
      rd(2'h1, 16'd1010 + 16'(10 * i), hmsw[i], 8'h00);
    rd(2'h1, 16'd8040, 16'h0013, 8'h00);
    rd(2'h1, 16'd2010, 16'h0000, 8'h02);
    wr(16'd120, 16'h0001, 8'h00);
    wr(16'd120, 16'h0002, 8'h01);
    `CHK(LASER_ON, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      wr(16'd130, 16'(i), 8'h00);
      `CHK(RELAY_CTRL, 2'(i))
    end
    wr(16'd130, 16'h0004, 8'h01);
    `CHK(RELAY_CTRL, 2'h3)
    foreach (modes[i])
    begin
      wr(16'd510, modes[i], 8'h00);
      `CHK(AO_MODE[15:0], modes[i])
    end
    wr(16'd510, 16'h000b, 8'h04);
    wr(16'd530, 16'h0009, 8'h03);
    wr(16'd520, 16'h0009, 8'h00);
    `CHK(AO_MODE, 32'h0009_0063)
    wr(16'd510, 16'h0009, 8'h00);
    wr32(16'd513, 32'h4080_0000, 8'h00);
    wr32(16'd513, 32'h40c0_0000, 8'h01);
    `CHK(AO_FIXED[31:0], 32'h4080_0000)
    wr(16'd514, 16'h0000, 8'h01);
    wr(16'd510, 16'h000a, 8'h00);
    wr32(16'd513, 32'h40c0_0000, 8'h00);
    `CHK(AO_FIXED[31:0], 32'h40c0_0000)
    rd(2'h2, 16'd510, 16'h000a, 8'h00);
    wr(16'd511, 16'h0002, 8'h02);
    wr(16'd511, 16'h0001, 8'h00);
    wr(16'd512, 16'h0001, 8'h00);
    wr(16'd512, 16'h0003, 8'h01);
    `CHK({AO_SOURCE[15:0], AO_QUANTITY[15:0]}, 32'h0001_0001)
    wr(16'd510, 16'h0005, 8'h00);
    wr32(16'd513, 32'h4348_0000, 8'h01);
    wr32(16'd515, 32'h4248_0000, 8'h00);
    wr32(16'd517, 32'h4348_0000, 8'h01);
    `CHK({AO_SCALE_LOW[31:0], AO_SCALE_HIGH[31:0]}, 64'h4248_0000_0000_0000)
    wr32(16'd1100, 32'h41a0_0000, 8'h00);
    `CHK(HEAD_AMBIENT_COMP[31:0], 32'h41a0_0000)
    final_report();
  end
endmodule
